// File: include/pdq_pkg.sv
package pdq_pkg;

  // Register bank layout, one aligned word each, 16 bits of data
  localparam int          PDQ_NREG = 37;
  localparam int          PDQ_DW   = 16;
  localparam logic [11:0] PDQ_OFFS [PDQ_NREG] = '{
    12'h700, 12'h704, 12'h708, 12'h70c, 12'h710, 12'h714, 12'h718,
    12'h71c, 12'h730, 12'h734, 12'h738, 12'h73c, 12'h740, 12'h744,
    12'h750, 12'h754, 12'h770, 12'h774, 12'h780, 12'h790, 12'h794,
    12'h800, 12'h804, 12'h808, 12'h80c, 12'h810, 12'h830, 12'h834,
    12'h838, 12'h83c, 12'h840, 12'h844, 12'h850, 12'h854, 12'h870,
    12'h874, 12'h880};

  // Indices into the bank for registers the engine and the channel select/data access use
  localparam int PDQ_I_FQ_END   = 2;
  localparam int PDQ_I_FQ_SMALL = 3;
  localparam int PDQ_I_LG_WR    = 4;
  localparam int PDQ_I_SM_WR    = 5;
  localparam int PDQ_I_LG_RD    = 6;
  localparam int PDQ_I_SM_RD    = 7;
  localparam int PDQ_I_DQ_END   = 10;
  localparam int PDQ_I_DQ_WR    = 12;
  localparam int PDQ_I_RX_SEL   = 16;
  localparam int PDQ_I_RX_DATA  = 17;
  localparam int PDQ_I_LSIZE    = 19;
  localparam int PDQ_I_SSIZE    = 20;
  localparam int PDQ_I_TX_SEL   = 34;
  localparam int PDQ_I_TX_DATA  = 35;

  // Extra control and interrupt registers
  localparam logic [11:0] PDQ_OFF_CTRL  = 12'h900;
  localparam logic [11:0] PDQ_OFF_ISTAT = 12'h904;
  localparam logic [11:0] PDQ_OFF_IMASK = 12'h908;
  localparam int          PDQ_CTRL_RX_EN = 0;
  localparam int          PDQ_CTRL_TX_EN = 1;
  localparam int          PDQ_IRQ_DONE   = 0;
  localparam int          PDQ_IRQ_STARVE = 1;
  localparam int          PDQ_NIRQ       = 2;

  // Field widths and reset values
  localparam int               PDQ_SIZE_W = 13;
  localparam int               PDQ_CHAN_W = 8;
  localparam int               PDQ_NCHAN  = 256;
  localparam logic [15:0]      PDQ_RST16  = 16'h0000;
  localparam logic [1:0]       PDQ_MODE_LARGE = 2'h0;
  localparam logic [1:0]       PDQ_MODE_SMALL = 2'h1;
  localparam logic [1:0]       PDQ_MODE_MIX   = 2'h2;

  // Engine states
  typedef enum logic [2:0] {
    PDQ_IDLE = 3'b001,
    PDQ_PICK = 3'b010,
    PDQ_EMIT = 3'b100
  } pdq_state_t;

endpackage

// File: logic/pdq_rx_dma.sv
`timescale 1ns/10ps
// Functional notes
// - Receive data is scattered over host buffers, one buffer at a time.
// - Each used buffer reports its byte count and status to descriptor.
// - DMA hands back done entries so host knows data is ready.
// - Two buffer classes, large and small, sized by host registers.
// - Large size is 13 bits, zero is 0 bytes, 1FFCh is 8188.
// - Small size is 13 bits with the same encoding as large.
// - Size registers read/write, reset to zero, bits 13 to 15 unused.
// - 32-bit base addresses split into lower then upper word registers.
// - Free queue keeps large and small pointers plus small start.
// - Done queue has end, DMA write, host read pointers, flush timer.
// - Transmit pending queue has base, end, host write, DMA read.
// - 256 channel configs reached through select plus data registers.
// - DMA resets disabled; host sets receive and transmit enables.
// - Channel uses large only, small only, or small then large.
module pdq_rx_dma
  import pdq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Packet request from receive FIFO
  input  wire logic        pkt_valid,
  input  wire logic [15:0] pkt_bytes,
  input  wire logic [7:0]  pkt_chan,
  output logic             pkt_ready,
  // Buffer fill request to memory writer
  output logic             buf_valid,
  input  wire logic        buf_ready,
  output logic             buf_small,
  output logic [15:0]      buf_entry,
  output logic [12:0]      buf_count,
  output logic             buf_last,
  output logic [7:0]       buf_chan,
  // Enables and interrupt
  output logic             rx_enable,
  output logic             tx_enable,
  output logic             irq
);

  // Register index lookup, -1 when unmapped
  function automatic int reg_index(input logic [11:0] a);
    int r;
    r = -1;
    for (int i = 0; i < PDQ_NREG; i++) begin
      if (PDQ_OFFS[i] == a) begin
        r = i;
      end
    end
    return r;
  endfunction

  // Advance a queue pointer, wrapping to start past end
  function automatic logic [15:0] ptr_next(input logic [15:0] p,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    return (p >= hi) ? lo : 16'(p + 16'h0001);
  endfunction

  logic [15:0] regs_q [PDQ_NREG];
  logic [15:0] regs_d [PDQ_NREG];
  logic [15:0] rx_cfg_q [PDQ_NCHAN];
  logic [15:0] tx_cfg_q [PDQ_NCHAN];
  logic [1:0]  ctrl_q, ctrl_d;
  logic [PDQ_NIRQ-1:0] istat_q, istat_d, imask_q, imask_d;
  logic [31:0] prdata_q, prdata_d;
  logic        slverr_q, slverr_d;
  pdq_state_t  state_q, state_d;
  logic [15:0] rem_q, rem_d;
  logic [1:0]  mode_q, mode_d;
  logic        first_q, first_d;
  logic        bvalid_q, bvalid_d, bsmall_q, bsmall_d, blast_q, blast_d;
  logic [15:0] bentry_q, bentry_d;
  logic [12:0] bcount_q, bcount_d;
  logic [7:0]  bchan_q, bchan_d;
  logic        setup, wr_acc;
  int          widx;
  logic [7:0]  rx_sel, tx_sel;
  logic        use_small, empty;
  logic [15:0] size16;

  // APB phases: read data captured in setup, answer in access
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && !slverr_q;
  assign widx    = reg_index(paddr);
  assign pready  = psel && penable;
  assign prdata  = prdata_q;
  assign pslverr = pready && slverr_q;
  assign rx_sel  = regs_q[PDQ_I_RX_SEL][PDQ_CHAN_W-1:0];
  assign tx_sel  = regs_q[PDQ_I_TX_SEL][PDQ_CHAN_W-1:0];
  assign rx_enable = ctrl_q[PDQ_CTRL_RX_EN];
  assign tx_enable = ctrl_q[PDQ_CTRL_TX_EN];
  assign irq       = |(istat_q & imask_q);
  assign pkt_ready = rx_enable && (state_q == PDQ_IDLE);

  // Buffer class and size for the next chunk
  always_comb begin
    use_small = (mode_q == PDQ_MODE_SMALL) ||
                ((mode_q == PDQ_MODE_MIX) && first_q);
    size16 = use_small ?
             {3'h0, regs_q[PDQ_I_SSIZE][PDQ_SIZE_W-1:0]} :
             {3'h0, regs_q[PDQ_I_LSIZE][PDQ_SIZE_W-1:0]};
    empty = use_small ?
            (regs_q[PDQ_I_SM_WR] == regs_q[PDQ_I_SM_RD]) :
            (regs_q[PDQ_I_LG_WR] == regs_q[PDQ_I_LG_RD]);
  end

  // Register bank, APB read data and engine next state
  always_comb begin
    regs_d   = regs_q;
    ctrl_d   = ctrl_q;
    imask_d  = imask_q;
    istat_d  = istat_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    state_d  = state_q;
    rem_d    = rem_q;
    mode_d   = mode_q;
    first_d  = first_q;
    bvalid_d = bvalid_q;
    bsmall_d = bsmall_q;
    blast_d  = blast_q;
    bentry_d = bentry_q;
    bcount_d = bcount_q;
    bchan_d  = bchan_q;
    // Setup cycle: decode and fetch read data
    if (setup) begin
      slverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      if (widx == PDQ_I_RX_DATA) begin
        prdata_d[15:0] = rx_cfg_q[rx_sel];
      end else if (widx == PDQ_I_TX_DATA) begin
        prdata_d[15:0] = tx_cfg_q[tx_sel];
      end else if (widx >= 0) begin
        prdata_d[15:0] = regs_q[widx];
      end else if (paddr == PDQ_OFF_CTRL) begin
        prdata_d[1:0] = ctrl_q;
      end else if (paddr == PDQ_OFF_ISTAT) begin
        prdata_d[PDQ_NIRQ-1:0] = istat_q;
      end else if (paddr == PDQ_OFF_IMASK) begin
        prdata_d[PDQ_NIRQ-1:0] = imask_q;
      end else begin
        slverr_d = 1'b1;
      end
    end
    // Access cycle: writes take effect
    if (wr_acc) begin
      if ((widx == PDQ_I_LSIZE) || (widx == PDQ_I_SSIZE)) begin
        regs_d[widx] = {3'h0, pwdata[PDQ_SIZE_W-1:0]};
      end else if ((widx >= 0) && (widx != PDQ_I_RX_DATA) &&
                   (widx != PDQ_I_TX_DATA)) begin
        regs_d[widx] = pwdata[15:0];
      end else if (paddr == PDQ_OFF_CTRL) begin
        ctrl_d = pwdata[1:0];
      end else if (paddr == PDQ_OFF_ISTAT) begin
        istat_d = istat_q & ~pwdata[PDQ_NIRQ-1:0];
      end else if (paddr == PDQ_OFF_IMASK) begin
        imask_d = pwdata[PDQ_NIRQ-1:0];
      end
    end
    // Receive engine
    case (state_q)
      PDQ_IDLE: begin
        if (pkt_valid && pkt_ready) begin
          rem_d   = pkt_bytes;
          bchan_d = pkt_chan;
          mode_d  = rx_cfg_q[pkt_chan][1:0];
          first_d = 1'b1;
          state_d = PDQ_PICK;
        end
      end
      PDQ_PICK: begin
        // Wait for a free entry of the class and a nonzero size
        if (empty || (size16 == 16'h0000)) begin
          istat_d[PDQ_IRQ_STARVE] = 1'b1;
        end else begin
          bvalid_d = 1'b1;
          bsmall_d = use_small;
          bentry_d = use_small ? regs_q[PDQ_I_SM_RD] :
                                 regs_q[PDQ_I_LG_RD];
          blast_d  = (rem_q <= size16);
          bcount_d = (rem_q <= size16) ? rem_q[PDQ_SIZE_W-1:0] :
                                         size16[PDQ_SIZE_W-1:0];
          state_d  = PDQ_EMIT;
        end
      end
      PDQ_EMIT: begin
        if (buf_ready) begin
          bvalid_d = 1'b0;
          first_d  = 1'b0;
          rem_d    = 16'(rem_q - {3'h0, bcount_q});
          // Hardware pointer advance wins over a same-cycle host write
          if (bsmall_q) begin
            regs_d[PDQ_I_SM_RD] = ptr_next(regs_q[PDQ_I_SM_RD],
              regs_q[PDQ_I_FQ_SMALL], regs_q[PDQ_I_FQ_END]);
          end else begin
            regs_d[PDQ_I_LG_RD] = ptr_next(regs_q[PDQ_I_LG_RD],
              PDQ_RST16, 16'(regs_q[PDQ_I_FQ_SMALL] - 16'h0001));
          end
          if (blast_q) begin
            regs_d[PDQ_I_DQ_WR] = ptr_next(regs_q[PDQ_I_DQ_WR],
              PDQ_RST16, regs_q[PDQ_I_DQ_END]);
            istat_d[PDQ_IRQ_DONE] = 1'b1;
            state_d = PDQ_IDLE;
          end else begin
            state_d = PDQ_PICK;
          end
        end
      end
      default: begin
        state_d = PDQ_IDLE;
      end
    endcase
  end

  // Channel configuration memories, written through the data register
  always_ff @(posedge clk) begin
    if (wr_acc && (widx == PDQ_I_RX_DATA)) begin
      rx_cfg_q[rx_sel] <= pwdata[15:0];
    end
    if (wr_acc && (widx == PDQ_I_TX_DATA)) begin
      tx_cfg_q[tx_sel] <= pwdata[15:0];
    end
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PDQ_NREG; i++) begin
        regs_q[i] <= PDQ_RST16;
      end
      ctrl_q   <= 2'h0;
      istat_q  <= '0;
      imask_q  <= '0;
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      state_q  <= PDQ_IDLE;
      rem_q    <= 16'h0000;
      mode_q   <= 2'h0;
      first_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bsmall_q <= 1'b0;
      blast_q  <= 1'b0;
      bentry_q <= 16'h0000;
      bcount_q <= 13'h0000;
      bchan_q  <= 8'h00;
    end else begin
      regs_q   <= regs_d;
      ctrl_q   <= ctrl_d;
      istat_q  <= istat_d;
      imask_q  <= imask_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
      state_q  <= state_d;
      rem_q    <= rem_d;
      mode_q   <= mode_d;
      first_q  <= first_d;
      bvalid_q <= bvalid_d;
      bsmall_q <= bsmall_d;
      blast_q  <= blast_d;
      bentry_q <= bentry_d;
      bcount_q <= bcount_d;
      bchan_q  <= bchan_d;
    end
  end

  // Buffer request outputs
  assign buf_valid = bvalid_q;
  assign buf_small = bsmall_q;
  assign buf_entry = bentry_q;
  assign buf_count = bcount_q;
  assign buf_last  = blast_q;
  assign buf_chan  = bchan_q;

  // Register bank checks; size fields drop bits 15:13 on every write
  size_mask_a: assert property (@(posedge clk) disable iff (rst)
    regs_q[PDQ_I_LSIZE][15:13] == 3'h0 && regs_q[PDQ_I_SSIZE][15:13] == 3'h0)
    else $error("size register upper bits set");
  lsize_wr_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && widx == PDQ_I_LSIZE |=>
      regs_q[PDQ_I_LSIZE] == {3'h0, $past(pwdata[PDQ_SIZE_W-1:0])})
    else $error("large size write lost");
  ssize_wr_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && widx == PDQ_I_SSIZE |=>
      regs_q[PDQ_I_SSIZE] == {3'h0, $past(pwdata[PDQ_SIZE_W-1:0])})
    else $error("small size write lost");
  ctrl_wr_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && paddr == PDQ_OFF_CTRL |=> ctrl_q == $past(pwdata[1:0]))
    else $error("enable write lost");
  rd_upper_a: assert property (@(posedge clk) disable iff (rst)
    pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half set");
  apb_err_a: assert property (@(posedge clk) disable iff (rst)
    setup && widx < 0 && paddr != PDQ_OFF_CTRL && paddr != PDQ_OFF_ISTAT
      && paddr != PDQ_OFF_IMASK |=> pslverr || !penable)
    else $error("unmapped access not flagged");
  // Config RAM has no reset, so only reads are held against it; a write
  // setup may fetch a channel that was never written
  cfg_rd_a: assert property (@(posedge clk) disable iff (rst)
    setup && !pwrite && widx == PDQ_I_RX_DATA |=>
      prdata[15:0] == rx_cfg_q[rx_sel] && prdata[31:16] == 16'h0000)
    else $error("channel config read wrong");

  // Packet intake and starvation
  dis_gate_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_q[PDQ_CTRL_RX_EN] |-> !pkt_ready)
    else $error("packet taken while disabled");
  pkt_take_a: assert property (@(posedge clk) disable iff (rst)
    pkt_valid && pkt_ready |=> state_q == PDQ_PICK &&
      rem_q == $past(pkt_bytes) && buf_chan == $past(pkt_chan))
    else $error("packet not taken");
  mix_start_a: assert property (@(posedge clk) disable iff (rst)
    pkt_valid && pkt_ready |=> first_q)
    else $error("first chunk flag not set");
  // Starve is raised again on every waiting cycle, so a clear cannot hide it
  starve_set_a: assert property (@(posedge clk) disable iff (rst)
    state_q == PDQ_PICK && empty |=> istat_q[PDQ_IRQ_STARVE])
    else $error("starved wait not flagged");

  // Chunk requests
  buf_fit_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid |-> ({3'h0, buf_count} <= rem_q && buf_count != 13'h0000))
    else $error("buffer count out of range");
  last_fit_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && buf_last |-> {3'h0, buf_count} == rem_q)
    else $error("last chunk count wrong");
  buf_hold_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && !buf_ready |=> buf_valid && $stable(buf_count)
      && $stable(buf_entry))
    else $error("buffer request dropped");
  emit_next_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && buf_ready && !buf_last |=>
      state_q == PDQ_PICK && !buf_valid)
    else $error("chunk not retired");
  // Buffer class follows the channel mode latched at intake
  class_sel_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && mode_q == PDQ_MODE_LARGE |-> !buf_small)
    else $error("small buffer in large mode");
  small_only_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && mode_q == PDQ_MODE_SMALL |-> buf_small)
    else $error("large buffer in small mode");
  mix_first_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && mode_q == PDQ_MODE_MIX |-> buf_small == first_q)
    else $error("mix mode class wrong");

  // Pointer hand-back; a pointer only stands still on a one-entry range, or a small range whose start lies past its end
  done_irq_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && buf_ready && buf_last |=> istat_q[PDQ_IRQ_DONE]
      && regs_q[PDQ_I_DQ_WR] != $past(regs_q[PDQ_I_DQ_WR]))
    else $error("done entry not handed back");
  ptr_move_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && buf_ready && !buf_small |=>
      regs_q[PDQ_I_LG_RD] != $past(regs_q[PDQ_I_LG_RD]) ||
      regs_q[PDQ_I_FQ_SMALL] == 16'h0001)
    else $error("large read pointer stuck");
  ptr_small_a: assert property (@(posedge clk) disable iff (rst)
    buf_valid && buf_ready && buf_small |=>
      regs_q[PDQ_I_SM_RD] != $past(regs_q[PDQ_I_SM_RD]) ||
      regs_q[PDQ_I_FQ_SMALL] >= regs_q[PDQ_I_FQ_END])
    else $error("small read pointer stuck");

endmodule // pdq_rx_dma

// File: tb/packet_dma_queue_setup_rx_buffers_test.sv
`timescale 1ns/10ps
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module packet_dma_queue_setup_rx_buffers_test
  import pdq_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, pkt_valid;
  logic pkt_ready, buf_valid, buf_ready, buf_small, buf_last, slow, irq;
  logic rx_enable, tx_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pkt_bytes, buf_entry, d16;
  logic [7:0]  pkt_chan, buf_chan;
  logic [12:0] buf_count;
  logic        err;
  int miscompares = 0;
  int n_compared = 0;

  pdq_rx_dma dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid),
    .pkt_bytes(pkt_bytes), .pkt_chan(pkt_chan), .pkt_ready(pkt_ready),
    .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_small(buf_small),
    .buf_entry(buf_entry), .buf_count(buf_count), .buf_last(buf_last),
    .buf_chan(buf_chan), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .irq(irq));
  pdq_mem_model mem (.clk(clk), .rst(rst), .slow(slow),
    .buf_valid(buf_valid), .buf_small(buf_small), .buf_entry(buf_entry),
    .buf_count(buf_count), .buf_last(buf_last), .buf_chan(buf_chan),
    .buf_ready(buf_ready));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic test_done;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [15:0] d);
    apb(1'b1, PDQ_OFFS[i], {16'h0, d});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CMP(rd, e)
    `CMP(err, 1'b0)
  endtask

  // Offer one packet and wait until it is taken
  task automatic send(input logic [15:0] b, input logic [7:0] c);
    int n;
    n = 0;
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_bytes <= b;
    pkt_chan <= c;
    do begin
      @(posedge clk);
      n++;
    end while (pkt_ready !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
    pkt_valid <= 1'b0;
  endtask

  // Wait for chunk k at the memory writer and compare it
  task automatic chunk(input int k, input logic [38:0] e);
    int n;
    n = 0;
    while (mem.log.size() <= k && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (mem.log.size() > k) `CMP(mem.log[k], e)
    else miscompares++;
  endtask

  // Hang guard
  initial begin
    #40000;
    miscompares++;
    test_done;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pkt_valid = 1'b0;
    pkt_bytes = 16'h0;
    pkt_chan = 8'h00;
    slow = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values, engine disabled
    `CMP({rx_enable, tx_enable}, 2'b00)
    rdc(PDQ_OFF_CTRL, 32'h0);
    for (int i = 0; i < PDQ_NREG; i++)
      if (i != PDQ_I_RX_DATA && i != PDQ_I_TX_DATA)
        rdc(PDQ_OFFS[i], 32'h0);
    // Every setup word but the two data registers holds 16 bits, size fields 13; upper half zero
    for (int i = 0; i < PDQ_NREG; i++) begin
      d16 = 16'he000 ^ 16'(i * 16'h0123);
      wr(i, d16);
      if (i == PDQ_I_LSIZE || i == PDQ_I_SSIZE) d16 = d16 & 16'h1fff;
      if (i != PDQ_I_RX_DATA && i != PDQ_I_TX_DATA)
        rdc(PDQ_OFFS[i], {16'h0, d16});
    end
    wr(PDQ_I_LSIZE, 16'h1ffc);
    rdc(PDQ_OFFS[PDQ_I_LSIZE], 32'h1ffc);
    wr(PDQ_I_SSIZE, 16'hfffc);
    rdc(PDQ_OFFS[PDQ_I_SSIZE], 32'h1ffc);
    // Unmapped word is refused and reads zero
    apb(1'b1, 12'h7fc, 32'h1234);
    `CMP(err, 1'b1)
    apb(1'b0, 12'h7fc, 32'h0);
    `CMP({err, rd}, 33'h1_0000_0000)
    // Queue setup: large entries 0..3, small 4..7, sizes dword multiples
    wr(PDQ_I_FQ_END, 16'h7);
    wr(PDQ_I_FQ_SMALL, 16'h4);
    wr(PDQ_I_LG_WR, 16'h3);
    wr(PDQ_I_LG_RD, 16'h0);
    wr(PDQ_I_SM_WR, 16'h6);
    wr(PDQ_I_SM_RD, 16'h4);
    wr(PDQ_I_DQ_END, 16'h7);
    wr(PDQ_I_DQ_WR, 16'h0);
    wr(PDQ_I_LSIZE, 16'h10);
    wr(PDQ_I_SSIZE, 16'h8);
    wr(PDQ_I_RX_SEL, 16'h5);
    wr(PDQ_I_RX_DATA, {14'h0, PDQ_MODE_MIX});
    rdc(PDQ_OFFS[PDQ_I_RX_DATA], {30'h0, PDQ_MODE_MIX});
    apb(1'b1, PDQ_OFF_IMASK, 32'h3);
    apb(1'b1, PDQ_OFF_ISTAT, 32'h3);
    apb(1'b1, PDQ_OFF_CTRL, 32'h3);
    // Enables change on the edge the write lands; checked one edge later
    @(posedge clk);
    `CMP({rx_enable, tx_enable}, 2'b11)
    // Small first, then large, with a stalling writer
    send(16'd30, 8'h5);
    chunk(0, {1'b1, 16'h4, 13'd8, 1'b0, 8'h5});
    chunk(1, {1'b0, 16'h0, 13'd16, 1'b0, 8'h5});
    chunk(2, {1'b0, 16'h1, 13'd6, 1'b1, 8'h5});
    repeat (4) @(posedge clk);
    rdc(PDQ_OFFS[PDQ_I_SM_RD], 32'h5);
    rdc(PDQ_OFFS[PDQ_I_LG_RD], 32'h2);
    rdc(PDQ_OFFS[PDQ_I_DQ_WR], 32'h1);
    rdc(PDQ_OFF_ISTAT, 32'h1);
    `CMP(irq, 1'b1)
    apb(1'b1, PDQ_OFF_ISTAT, 32'h1);
    @(posedge clk);
    `CMP(irq, 1'b0)
    // Small only, no free small entry: stall until host adds one
    slow <= 1'b0;
    apb(1'b1, PDQ_OFF_IMASK, 32'h0);
    wr(PDQ_I_RX_DATA, {14'h0, PDQ_MODE_SMALL});
    wr(PDQ_I_SM_WR, 16'h5);
    send(16'd4, 8'h5);
    repeat (6) @(posedge clk);
    rdc(PDQ_OFF_ISTAT, 32'h2);
    `CMP(irq, 1'b0)
    apb(1'b1, PDQ_OFF_IMASK, 32'h2);
    @(posedge clk);
    `CMP(irq, 1'b1)
    `CMP(mem.log.size(), 3)
    wr(PDQ_I_SM_WR, 16'h6);
    chunk(3, {1'b1, 16'h5, 13'd4, 1'b1, 8'h5});
    repeat (4) @(posedge clk);
    apb(1'b1, PDQ_OFF_ISTAT, 32'h3);
    rdc(PDQ_OFF_ISTAT, 32'h0);
    `CMP(irq, 1'b0)
    // Large only
    wr(PDQ_I_RX_DATA, {14'h0, PDQ_MODE_LARGE});
    send(16'd16, 8'h5);
    chunk(4, {1'b0, 16'h2, 13'd16, 1'b1, 8'h5});
    test_done;
  end
endmodule // packet_dma_queue_setup_rx_buffers_test

// File: tb/pdq_mem_model.sv
`timescale 1ns/10ps
// Memory writer on the far side: takes buffer chunks, logs each one
module pdq_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Pace control
  input  wire logic        slow,
  // Chunk requests
  input  wire logic        buf_valid,
  input  wire logic        buf_small,
  input  wire logic [15:0] buf_entry,
  input  wire logic [12:0] buf_count,
  input  wire logic        buf_last,
  input  wire logic [7:0]  buf_chan,
  output logic             buf_ready
);
  logic [1:0]  cnt_q;
  logic [38:0] log [$];

  // Ready every cycle, or one cycle in four when stalling
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 2'h0;
      buf_ready <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 2'h1;
      buf_ready <= !slow || (cnt_q == 2'h3);
    end
  end

  // Each accepted chunk lands in its own buffer
  always @(posedge clk) begin
    if (!rst && buf_valid && buf_ready) begin
      log.push_back({buf_small, buf_entry, buf_count, buf_last, buf_chan});
    end
  end
endmodule // pdq_mem_model
